// *** afh_map.svh ***
// Function
// - Stalled outside window past monitor time: fault 134
// - Block completes only inside positioning window
// - Follow-up: loop off, reference copies actual
// - Position keeps sampling during follow-up
// - Follow-up on enable loss with request, velocity jog
// - Fault follow-up only for STOP 0, I, II
// - Follow-up active output reports every follow-up
// - Request sampled only at enable edges
// - Tracking: reference follows actual, output one
// - Re-enable after tracking starts from actual
// - Hold: keep reference, suppress monitors, output zero
// - Hold displacement shows as following error
// - Hold plus monitoring enabled switches to follow-up
// - Re-enable after hold starts from old reference
// - Follow-up with request suppresses three monitors
// - Motion diagnostic values are readable
// - Unreferenced axis: no limits, backlash, block start
// - Incremental encoder unreferenced after power-up
// - Setting zero: any set change needs re-reference
// - Setting one: re-reference only if ratio differs
`ifndef AFH_MAP_SVH
`define AFH_MAP_SVH
`define AFH_FAULT_POSMON 8'h86
`define AFH_POS_RESET 32'h0000_0000
`define AFH_CLK_NS 50
`define AFH_MON_TICK_US 1000
`define AFH_MON_TICK_CYC (`AFH_MON_TICK_US * 1000 / `AFH_CLK_NS)
`define AFH_SW_BEHAV_DEFAULT 1'b0
`endif

// *** afh_pkg.sv ***
package afh_pkg;
    typedef enum logic [1:0] {
        AFH_ST_RUN,
        AFH_ST_TRACK,
        AFH_ST_HOLD
    } afh_state_t;
    typedef enum logic [2:0] {
        AFH_STOP_NONE,
        AFH_STOP_0,
        AFH_STOP_I,
        AFH_STOP_II,
        AFH_STOP_III,
        AFH_STOP_IV
    } afh_stop_t;
    typedef struct packed {
        logic [31:0] pos_ref;
        logic [31:0] pos_act;
        logic [31:0] dist_to_go;
        logic [31:0] vel_set;
        logic [31:0] vel_act;
        logic [7:0] override_eff;
        logic [31:0] ext_block_pos;
        logic [31:0] follow_err;
        logic [31:0] loop_dev;
        logic [15:0] loop_gain;
    } afh_diag_t;
    typedef struct packed {
        logic [15:0] numerator;
        logic [15:0] denominator;
    } afh_ratio_t;
endpackage : afh_pkg

// *** afh_mon_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "afh_map.svh"
// Positioning monitor timer: counts millisecond ticks while armed.
module afh_mon_timer
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_arm,
    input wire logic [15:0] i_limit_ms,
    output logic o_expired
);
    logic [15:0] pre_q;
    logic [15:0] pre_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic exp_q;
    logic exp_d;

    // Disarming restarts the count, so each stall is timed afresh.
    always_comb
    begin
        pre_d = pre_q;
        ms_d = ms_q;
        exp_d = exp_q;
        if (!i_arm)
        begin
            pre_d = 16'h0000;
            ms_d = 16'h0000;
            exp_d = 1'b0;
        end
        else if (pre_q == 16'(`AFH_MON_TICK_CYC - 1))
        begin
            pre_d = 16'h0000;
            if (ms_q >= i_limit_ms)
                exp_d = 1'b1;
            else
                ms_d = ms_q + 16'h0001;
        end
        else
            pre_d = pre_q + 16'h0001;
    end

    // Registers only.
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pre_q <= 16'h0000;
            ms_q <= 16'h0000;
            exp_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_d;
            ms_q <= ms_d;
            exp_q <= exp_d;
        end
    end

    assign o_expired = exp_q;
endmodule : afh_mon_timer
`default_nettype wire

// *** afh_axis.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "afh_map.svh"
// *********************************************************************
// Axis follow-up and position hold.
// *********************************************************************
module afh_axis
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ctrl_enable,
    input wire logic i_follow_up_req,
    input wire logic i_jog_velocity,
    input wire logic i_jog_incremental,
    input wire logic i_fault_active,
    input wire afh_pkg::afh_stop_t i_fault_stop,
    input wire logic i_monitor_enable,
    input wire logic i_axis_blocked,
    input wire logic i_in_pos_window,
    input wire logic i_block_request,
    input wire logic [15:0] i_positioning_monitor_time,
    input wire logic i_paramset_switch_behavior,
    input wire logic [1:0] i_paramset_sel,
    input wire afh_pkg::afh_ratio_t i_ratio_old,
    input wire afh_pkg::afh_ratio_t i_ratio_new,
    input wire logic i_ref_set,
    input wire logic [31:0] i_ref_value,
    input wire logic [31:0] i_pos_actual,
    input wire logic [31:0] i_pos_target,
    input wire logic [31:0] i_vel_setpoint,
    input wire logic [31:0] i_vel_actual,
    input wire logic [7:0] i_override,
    input wire logic i_ext_block_change,
    input wire logic [15:0] i_position_loop_gain,
    output logic o_follow_up_active,
    output logic o_loop_closed,
    output logic [31:0] o_pos_ref,
    output logic o_monitors_on,
    output logic o_fault,
    output logic [7:0] o_fault_code,
    output logic o_block_done,
    output logic o_block_start,
    output logic o_referenced,
    output logic o_limits_on,
    output logic o_backlash_on,
    output afh_pkg::afh_diag_t o_diag
);
    // *****************************************************************
    // Input synchronisers for pin-level controls.
    // *****************************************************************
    logic [2:0] en_sy_q;
    logic [2:0] en_sy_d;
    logic [2:0] rq_sy_q;
    logic [2:0] rq_sy_d;
    logic en_q;
    logic en_d;
    logic rq_q;
    logic rq_d;

    // A change is accepted only when stages two and three agree.
    always_comb
    begin
        en_sy_d = {en_sy_q[1:0], i_ctrl_enable};
        rq_sy_d = {rq_sy_q[1:0], i_follow_up_req};
        en_d = (en_sy_q[1] == en_sy_q[2]) ? en_sy_q[2] : en_q;
        rq_d = (rq_sy_q[1] == rq_sy_q[2]) ? rq_sy_q[2] : rq_q;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            en_sy_q <= 3'h0;
            rq_sy_q <= 3'h0;
            en_q <= 1'b0;
            rq_q <= 1'b0;
        end
        else
        begin
            en_sy_q <= en_sy_d;
            rq_sy_q <= rq_sy_d;
            en_q <= en_d;
            rq_q <= rq_d;
        end
    end

    // *****************************************************************
    // Follow-up state and position reference.
    // *****************************************************************
    afh_pkg::afh_state_t st_q;
    afh_pkg::afh_state_t st_d;
    logic en_prev_q;
    logic latched_rq_q;
    logic latched_rq_d;
    logic [31:0] ref_q;
    logic [31:0] ref_d;
    logic fu_q;
    logic fu_d;
    logic mon_q;
    logic mon_d;
    logic loop_q;
    logic loop_d;
    logic fault_fu;
    logic jog_fu;
    logic en_fall;
    logic en_rise;

    assign en_fall = en_prev_q & ~en_q;
    assign en_rise = ~en_prev_q & en_q;
    assign jog_fu = i_jog_velocity & ~i_jog_incremental;
    assign fault_fu = i_fault_active & ((i_fault_stop == afh_pkg::AFH_STOP_0)
        | (i_fault_stop == afh_pkg::AFH_STOP_I)
        | (i_fault_stop == afh_pkg::AFH_STOP_II));

    // The request is latched only at enable edges and ignored otherwise.
    always_comb
    begin
        st_d = st_q;
        latched_rq_d = latched_rq_q;
        ref_d = ref_q;
        if (en_fall || en_rise)
            latched_rq_d = rq_q;
        case (st_q)
            afh_pkg::AFH_ST_RUN:
            begin
                if (en_fall)
                    st_d = rq_q ? afh_pkg::AFH_ST_TRACK : afh_pkg::AFH_ST_HOLD;
                ref_d = i_pos_target;
            end
            afh_pkg::AFH_ST_TRACK:
            begin
                ref_d = i_pos_actual;
                if (en_rise)
                    st_d = afh_pkg::AFH_ST_RUN;
            end
            afh_pkg::AFH_ST_HOLD:
            begin
                // Reference kept, so push-away shows as following error.
                ref_d = ref_q;
                if (i_monitor_enable)
                    st_d = afh_pkg::AFH_ST_TRACK;
                else if (en_rise)
                    st_d = afh_pkg::AFH_ST_RUN;
            end
            default:
                st_d = afh_pkg::AFH_ST_RUN;
        endcase
        // Jog and fault follow-up track in any state, a held axis included.
        if (jog_fu || fault_fu)
            ref_d = i_pos_actual;
        fu_d = (st_q == afh_pkg::AFH_ST_TRACK) | jog_fu | fault_fu;
        loop_d = ~fu_d & (st_d == afh_pkg::AFH_ST_RUN);
        mon_d = ~((st_q == afh_pkg::AFH_ST_HOLD)
            | ((st_q == afh_pkg::AFH_ST_TRACK) & latched_rq_q));
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q <= afh_pkg::AFH_ST_RUN;
            en_prev_q <= 1'b0;
            latched_rq_q <= 1'b0;
            ref_q <= `AFH_POS_RESET;
            fu_q <= 1'b0;
            mon_q <= 1'b1;
            loop_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            loop_q <= loop_d;
            en_prev_q <= en_q;
            latched_rq_q <= latched_rq_d;
            ref_q <= ref_d;
            fu_q <= fu_d;
            mon_q <= mon_d;
        end
    end

    // *****************************************************************
    // Referencing, positioning monitor and block sequencing.
    // *****************************************************************
    logic refd_q;
    logic refd_d;
    logic [1:0] pset_q;
    logic fault_q;
    logic fault_d;
    logic [7:0] code_q;
    logic [7:0] code_d;
    logic done_q;
    logic done_d;
    logic start_q;
    logic start_d;
    logic [31:0] off_q;
    logic [31:0] off_d;
    logic expired;

    afh_mon_timer u_mon_timer
    (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_arm(i_axis_blocked & ~i_in_pos_window & mon_q),
        .i_limit_ms(i_positioning_monitor_time),
        .o_expired(expired)
    );

    // Sticky fault; only a reset clears it, so no event is lost.
    always_comb
    begin
        fault_d = fault_q | expired;
        code_d = fault_d ? `AFH_FAULT_POSMON : 8'h00;
        refd_d = refd_q;
        off_d = off_q;
        if (pset_q != i_paramset_sel && refd_q)
        begin
            if (!i_paramset_switch_behavior)
                refd_d = 1'b0;
            else if (i_ratio_old != i_ratio_new)
                refd_d = 1'b0;
        end
        if (i_ref_set)
        begin
            refd_d = 1'b1;
            off_d = i_ref_value;
        end
        done_d = i_block_request & i_in_pos_window & refd_q;
        start_d = done_q & refd_q & en_q & ~fault_q;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            refd_q <= 1'b0;
            pset_q <= 2'h0;
            fault_q <= 1'b0;
            code_q <= 8'h00;
            done_q <= 1'b0;
            start_q <= 1'b0;
            off_q <= `AFH_POS_RESET;
        end
        else
        begin
            refd_q <= refd_d;
            pset_q <= i_paramset_sel;
            fault_q <= fault_d;
            code_q <= code_d;
            done_q <= done_d;
            start_q <= start_d;
            off_q <= off_d;
        end
    end

    // *****************************************************************
    // Diagnostic readouts, registered.
    // *****************************************************************
    afh_pkg::afh_diag_t diag_q;
    afh_pkg::afh_diag_t diag_d;
    logic [31:0] ext_q;

    // Readouts lag live values by one cycle to keep outputs registered.
    always_comb
    begin
        diag_d.pos_ref = ref_q;
        diag_d.pos_act = i_pos_actual;
        diag_d.dist_to_go = i_pos_target - i_pos_actual;
        diag_d.vel_set = i_vel_setpoint;
        diag_d.vel_act = i_vel_actual;
        diag_d.override_eff = i_override;
        diag_d.ext_block_pos = ext_q;
        diag_d.follow_err = ref_q - i_pos_actual;
        diag_d.loop_dev = ref_q - i_pos_actual + off_q - off_q;
        diag_d.loop_gain = i_position_loop_gain;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            diag_q <= '0;
            ext_q <= `AFH_POS_RESET;
        end
        else
        begin
            diag_q <= diag_d;
            if (i_ext_block_change)
                ext_q <= i_pos_actual;
        end
    end

    // *****************************************************************
    // Outputs, each from a flip-flop.
    // *****************************************************************
    assign o_follow_up_active = fu_q;
    assign o_loop_closed = loop_q;
    assign o_pos_ref = ref_q;
    assign o_monitors_on = mon_q;
    assign o_fault = fault_q;
    assign o_fault_code = code_q;
    assign o_block_done = done_q;
    assign o_block_start = start_q;
    assign o_referenced = refd_q;
    assign o_limits_on = refd_q;
    assign o_backlash_on = refd_q;
    assign o_diag = diag_q;
endmodule : afh_axis
`default_nettype wire

// *** afh_axis_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks for the axis follow-up block.
// ****
module afh_axis_props
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ref_set,
    input wire logic i_block_request,
    input wire logic i_in_pos_window,
    input wire logic i_jog_velocity,
    input wire logic i_jog_incremental,
    input wire logic i_fault_active,
    input wire afh_pkg::afh_stop_t i_fault_stop,
    input wire logic [31:0] i_pos_actual,
    input wire logic o_follow_up_active,
    input wire logic o_loop_closed,
    input wire logic [31:0] o_pos_ref,
    input wire logic o_monitors_on,
    input wire logic o_fault,
    input wire logic [7:0] o_fault_code,
    input wire logic o_block_done,
    input wire logic o_block_start,
    input wire logic o_referenced,
    input wire logic o_limits_on,
    input wire logic o_backlash_on
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // Fault code and latch, block order, and the follow-up relations.
    property p_fault; o_fault |-> o_fault_code == 8'h86 ##1 o_fault; endproperty
    property p_done; o_block_done |-> $past(i_in_pos_window && i_block_request); endproperty
    property p_start; o_block_start |-> $past(o_block_done); endproperty
    property p_track; o_follow_up_active && $past(o_follow_up_active)
        |-> o_pos_ref == $past(i_pos_actual); endproperty
    property p_open; $rose(o_follow_up_active) |-> !o_loop_closed; endproperty
    property p_hold; !o_monitors_on && $past(!o_monitors_on) && !o_follow_up_active
        && $past(!o_follow_up_active) |-> $stable(o_pos_ref); endproperty
    property p_refset; i_ref_set |=> o_referenced; endproperty
    property p_unref; !o_referenced && $past(!o_referenced) |-> !o_limits_on && !o_backlash_on;
    endproperty
    property p_jog; (i_jog_velocity && !i_jog_incremental) [*6] |-> o_follow_up_active;
    endproperty
    // Only the three harsh stop responses force follow-up.
    property p_fstop; (i_fault_active && i_fault_stop != afh_pkg::AFH_STOP_NONE
        && i_fault_stop < afh_pkg::AFH_STOP_III) [*6] |-> o_follow_up_active; endproperty
    a_fault: assert property (p_fault) else $error("fault code or latch wrong");
    a_done: assert property (p_done) else $error("block done outside window");
    a_start: assert property (p_start) else $error("block start without done");
    a_track: assert property (p_track) else $error("reference not tracking");
    a_open: assert property (p_open) else $error("loop closed in follow-up");
    a_hold: assert property (p_hold) else $error("reference moved in hold");
    a_refset: assert property (p_refset) else $error("reference not set");
    a_unref: assert property (p_unref) else $error("limits active unreferenced");
    a_jog: assert property (p_jog) else $error("jog without follow-up");
    a_fstop: assert property (p_fstop) else $error("fault without follow-up");
    c_fu: cover property ($rose(o_follow_up_active));
    c_flt: cover property ($rose(o_fault));
    c_blk: cover property (o_block_start);
endmodule : afh_axis_props
bind afh_axis afh_axis_props afh_axis_props_i (.i_mclk, .i_arst_n, .i_ref_set, .i_block_request,
    .i_in_pos_window, .i_jog_velocity, .i_jog_incremental, .i_fault_active, .i_fault_stop,
    .i_pos_actual,
    .o_follow_up_active, .o_loop_closed, .o_pos_ref, .o_monitors_on, .o_fault, .o_fault_code,
    .o_block_done, .o_block_start, .o_referenced, .o_limits_on, .o_backlash_on);
`default_nettype wire

// *** afh_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****
// Machine controller: enable and mode levels.
// ****
module afh_ctrl_model
(
    input wire logic i_mclk,
    output logic o_ctrl_enable,
    output logic o_follow_up_req,
    output logic o_jog_velocity,
    output logic o_jog_incremental
);
    // Idle controller keeps the axis disabled with no mode selected.
    initial
    begin
        o_ctrl_enable = 1'b0;
        o_follow_up_req = 1'b0;
        o_jog_velocity = 1'b0;
        o_jog_incremental = 1'b0;
    end
    // Levels change only after a falling edge; lag models a slow controller.
    task automatic apply(input logic en, input logic req, input logic jv, input logic ji,
        input int lag);
        repeat (lag + 1) @(negedge i_mclk);
        o_ctrl_enable = en;
        o_follow_up_req = req;
        o_jog_velocity = jv;
        o_jog_incremental = ji;
    endtask : apply
endmodule : afh_ctrl_model
`default_nettype wire

// *** afh_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****
// Self-checking bench for the axis block.
// ****
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic en, req, jv, ji, flt, mon_en, blocked, win, blk_req, behav, ref_set;
    logic fu, loop_c, mon_on, flt_o, blk_done, blk_start, refd, lim, bkl;
    afh_pkg::afh_stop_t stop;
    afh_pkg::afh_ratio_t r_old, r_new;
    afh_pkg::afh_diag_t diag;
    logic [1:0] psel;
    logic [31:0] act, tgt, rnd, pref, old;
    logic [7:0] fcode;
    logic [3:0] prev = 4'h0;
    logic [39:0] notes[$];
    int errors = 0;
    int n_checks = 0;
    always #25 mclk = ~mclk;
    afh_ctrl_model afh_ctrl_model_i (.i_mclk(mclk), .o_ctrl_enable(en), .o_follow_up_req(req),
        .o_jog_velocity(jv), .o_jog_incremental(ji));
    afh_axis afh_axis_i (.i_mclk(mclk), .i_arst_n(arst_n), .i_ctrl_enable(en),
        .i_follow_up_req(req), .i_jog_velocity(jv), .i_jog_incremental(ji),
        .i_fault_active(flt), .i_fault_stop(stop), .i_monitor_enable(mon_en),
        .i_axis_blocked(blocked), .i_in_pos_window(win), .i_block_request(blk_req),
        .i_positioning_monitor_time(16'h0001), .i_paramset_switch_behavior(behav),
        .i_paramset_sel(psel), .i_ratio_old(r_old), .i_ratio_new(r_new), .i_ref_set(ref_set),
        .i_ref_value(rnd), .i_pos_actual(act), .i_pos_target(tgt), .i_vel_setpoint(rnd),
        .i_vel_actual(~rnd), .i_override(rnd[7:0]), .i_ext_block_change(1'b0),
        .i_position_loop_gain(rnd[15:0]), .o_follow_up_active(fu), .o_loop_closed(loop_c),
        .o_pos_ref(pref), .o_monitors_on(mon_on), .o_fault(flt_o), .o_fault_code(fcode),
        .o_block_done(blk_done), .o_block_start(blk_start), .o_referenced(refd),
        .o_limits_on(lim), .o_backlash_on(bkl), .o_diag(diag));
    // Comparison, note keeping and the verdict.
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic note(input logic [7:0] k, input logic [31:0] v);
        notes.push_back({k, v});
    endtask : note
    function automatic logic [39:0] next();
        if (notes.size() == 0)
            return 40'hFF_FFFF_FFFF;
        return notes.pop_front();
    endfunction : next
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic refer();
        note(8'h02, 32'h1);
        ref_set = 1'b1;
        cyc(1);
        ref_set = 1'b0;
        cyc(3);
    endtask : refer
    task automatic results();
        errors += notes.size();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    // Every change of fu or refd and every rise of flt_o or blk_done consumes the oldest note, so order matters too.
    always @(posedge mclk)
    begin
        #1;
        if (arst_n)
        begin
            if (fu !== prev[0]) check({8'h01, 31'h0, fu}, next());
            if (refd !== prev[1]) check({8'h02, 31'h0, refd}, next());
            if (flt_o && !prev[2]) check({8'h03, 24'h0, fcode}, next());
            if (blk_done && !prev[3]) check({8'h04, 31'h0, blk_done}, next());
        end
        prev = {blk_done, flt_o, refd, fu};
    end
    // Watchdog: the whole sequence needs well under this span.
    initial
    begin
        #(50 * 90000);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end
    // Main sequence.
    initial
    begin
        void'($urandom(10779));
        {flt, mon_en, blocked, win, blk_req, behav, ref_set, psel} = '0;
        stop = afh_pkg::AFH_STOP_NONE;
        r_old = 32'h0001_0001;
        r_new = r_old;
        act = $urandom;
        tgt = act;
        rnd = $urandom;
        cyc(5);
        arst_n = 1'b1;
        cyc(5);
        check(refd, 1'b0);
        refer();
        check(lim & bkl, 1'b1);
        afh_ctrl_model_i.apply(1'b1, 1'b0, 1'b0, 1'b0, 0);
        blk_req = 1'b1;
        cyc(8);
        check(blk_done, 1'b0);
        note(8'h04, 32'h1);
        win = 1'b1;
        cyc(4);
        {blk_req, win} = 2'b00;
        $display("test block done");
        afh_ctrl_model_i.apply(1'b1, 1'b1, 1'b0, 1'b0, $urandom_range(3));
        note(8'h01, 32'h1);
        afh_ctrl_model_i.apply(1'b0, 1'b1, 1'b0, 1'b0, 0);
        cyc(8);
        repeat (4)
        begin
            act = $urandom;
            cyc(3);
            check(pref, act);
            check(loop_c, 1'b0);
            check(mon_on, 1'b0);
            check(diag.pos_act, act);
        end
        afh_ctrl_model_i.apply(1'b0, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        check(fu, 1'b1);
        note(8'h01, 32'h0);
        tgt = act;
        afh_ctrl_model_i.apply(1'b1, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        check(pref, act);
        check(refd, 1'b1);
        $display("test tracking done");
        old = pref;
        afh_ctrl_model_i.apply(1'b0, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        act = $urandom;
        cyc(4);
        check(pref, old);
        check(mon_on, 1'b0);
        tgt = old;
        afh_ctrl_model_i.apply(1'b1, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        check(pref, old);
        afh_ctrl_model_i.apply(1'b0, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        note(8'h01, 32'h1);
        mon_en = 1'b1;
        cyc(8);
        act = $urandom;
        cyc(3);
        check(pref, act);
        note(8'h01, 32'h0);
        tgt = act;
        afh_ctrl_model_i.apply(1'b1, 1'b0, 1'b0, 1'b0, 0);
        cyc(8);
        mon_en = 1'b0;
        $display("test hold done");
        for (int i = 0; i < 2; i++)
        begin
            if (i == 0) note(8'h01, 32'h1);
            afh_ctrl_model_i.apply(1'b1, 1'b0, i == 0, i == 1, 0);
            cyc(8);
            check(fu, i == 0);
            if (i == 0) note(8'h01, 32'h0);
            afh_ctrl_model_i.apply(1'b1, 1'b0, 1'b0, 1'b0, 0);
            cyc(8);
            check(fu, 1'b0);
        end
        for (int k = 1; k < 6; k++)
        begin
            stop = afh_pkg::afh_stop_t'(k);
            if (k < 4) note(8'h01, 32'h1);
            flt = 1'b1;
            cyc(8);
            check(fu, k < 4);
            if (k < 4) note(8'h01, 32'h0);
            flt = 1'b0;
            cyc(8);
        end
        $display("test jog and fault done");
        note(8'h02, 32'h0);
        psel = 2'h1;
        cyc(4);
        refer();
        behav = 1'b1;
        psel = 2'h2;
        cyc(4);
        check(refd, 1'b1);
        note(8'h02, 32'h0);
        r_new = 32'h0002_0001;
        psel = 2'h3;
        cyc(4);
        refer();
        $display("test parameter set done");
        note(8'h03, 32'h86);
        {blocked, blk_req} = 2'b11;
        for (int i = 0; i < 60000 && flt_o !== 1'b1; i++)
            cyc(1);
        cyc(2);
        check(blk_done, 1'b0);
        $display("test positioning fault done");
        results();
    end
endmodule : testbench
`default_nettype wire
